//--- include/frd_pkg.sv
// Constants shared by the FIFO readiness and alternate function block.
// Assumes a host bus with two active-low chip selects and a 3-bit address.
package frd_pkg;

	// Register addresses on the host bus.
	localparam logic [2:0] ADDR_ALT_FUNC = 3'h2;
	localparam logic [2:0] ADDR_FIFO_READY = 3'h7;

	// Line control bits 7 to 5 must hold this value to open alt functions.
	localparam logic [2:0] LINE_ALT_KEY = 3'h4;

	// Modem control field positions.
	localparam int MODEM_READY_EN_BIT = 2;
	localparam int MODEM_LOOPBACK_BIT = 4;

	// Alternate function field positions and reset value.
	localparam int ALT_DUAL_BIT = 0;
	localparam int ALT_SIR_BIT = 1;
	localparam int ALT_HDX_BIT = 2;
	localparam logic [7:0] ALT_FUNC_RESET = 8'h00;

	// Readiness register field positions.
	localparam int RDY_TX_A_BIT = 0;
	localparam int RDY_TX_B_BIT = 1;
	localparam int RDY_RX_A_BIT = 4;
	localparam int RDY_RX_B_BIT = 5;

	// The trigger level register counts in units of four entries.
	localparam int TRIG_UNIT_SHIFT = 2;

	// Levels picked by the FIFO control register when the level nibble is 0.
	localparam logic [6:0] SEL_TX_LVL0 = 7'h08;
	localparam logic [6:0] SEL_TX_LVL1 = 7'h10;
	localparam logic [6:0] SEL_TX_LVL2 = 7'h20;
	localparam logic [6:0] SEL_TX_LVL3 = 7'h38;
	localparam logic [6:0] SEL_RX_LVL0 = 7'h08;
	localparam logic [6:0] SEL_RX_LVL1 = 7'h10;
	localparam logic [6:0] SEL_RX_LVL2 = 7'h38;
	localparam logic [6:0] SEL_RX_LVL3 = 7'h3C;

	// Reset value of the read data latch.
	localparam logic [7:0] RDATA_RESET = 8'h00;

	// Width of one synchronised host bus sample.
	localparam int BUS_W = 15;

endpackage : frd_pkg

//--- src/frd_regs.sv
// Shared FIFO readiness status and per-channel alternate function control.
// Assumes the host bus pins are asynchronous to ref_clk and that the host
// holds address, data and selects stable around each strobe for at least
// three clocks; FIFO counts and control registers come from ref_clk logic.
// Functional notes
// RULE1: Bit 0 is 1 when channel A TX free space reaches its trigger level.
// RULE2: Bit 1 is 1 when channel B TX free space reaches its trigger level.
// RULE3: Bit 4 is 1 when channel A RX fill exceeds trigger or timed out.
// RULE4: Bit 5 is 1 when channel B RX fill exceeds trigger or timed out.
// RULE5: Readiness bits 2, 3, 6, 7 read zero; writes there do nothing.
// RULE6: Readable only with a select low, ready enable on, loopback off.
// RULE7: Under those conditions readiness replaces the normal register at 111.
// RULE8: Alternate function register at 010 only while line bits 7:5 = 100.
// RULE9: Concurrent write bit makes each host write reach both channels.
// RULE10: Host enables indirect addressing before concurrent writes.
// RULE11: Infrared bit switches the channel serial path to SIR coding.
// RULE12: Host uses SIR only from 2400 up to 115.2 k.
// RULE13: Each channel has a driver-enable pin held while TX data pends; the code holds it only while the half-duplex bit is set.
// RULE14: Trigger is level nibble times four, else FIFO control choice.
// RULE15: Half-duplex bit raises driver enable while TX data is held.
`timescale 1ns/100ps

module frd_regs
	import frd_pkg::*;
#(
	parameter int FIFO_DEPTH = 64,
	parameter int CNT_W = 7
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst_n,
	// Host bus pins.
	input wire logic chan_a_select_n,
	input wire logic chan_b_select_n,
	input wire logic host_rd_n,
	input wire logic host_wr_n,
	input wire logic [2:0] host_addr,
	input wire logic [7:0] host_wdata,
	output logic [7:0] host_rdata,
	output logic host_rdata_oe,
	// Channel A state and registers.
	input wire logic [CNT_W-1:0] tx_space_a,
	input wire logic [CNT_W-1:0] rx_fill_a,
	input wire logic rx_timeout_a,
	input wire logic [7:0] trigger_level_register_a,
	input wire logic [7:0] fifo_control_register_a,
	input wire logic [7:0] modem_control_register_a,
	input wire logic [7:0] line_control_register_a,
	input wire logic tx_pending_a,
	input wire logic [7:0] normal_rdata_a,
	// Channel B state and registers.
	input wire logic [CNT_W-1:0] tx_space_b,
	input wire logic [CNT_W-1:0] rx_fill_b,
	input wire logic rx_timeout_b,
	input wire logic [7:0] trigger_level_register_b,
	input wire logic [7:0] fifo_control_register_b,
	input wire logic [7:0] modem_control_register_b,
	input wire logic [7:0] line_control_register_b,
	input wire logic tx_pending_b,
	input wire logic [7:0] normal_rdata_b,
	// Write strobes toward the channel register sets.
	output logic wr_strobe_a,
	output logic wr_strobe_b,
	output logic [2:0] wr_addr,
	output logic [7:0] wr_data,
	// Mode controls and pins.
	output logic [7:0] alternate_function_control_a,
	output logic [7:0] alternate_function_control_b,
	output logic infrared_mode_enable_a,
	output logic infrared_mode_enable_b,
	output logic bus_driver_enable_out_a,
	output logic bus_driver_enable_out_b
);

	if (CNT_W < $clog2(FIFO_DEPTH + 1) || CNT_W > 7) begin : g_bad_cnt_w
		$error("CNT_W cannot hold the FIFO fill range");
	end

	// Level register nibble times four, or the FIFO control choice if zero.
	function automatic logic [6:0] trig_lvl(input logic [3:0] lvl_nib,
			input logic [1:0] ctl_sel, input logic is_tx);
		logic [6:0] lvl;
		lvl = 7'h00;
		if (lvl_nib != 4'h0) begin
			lvl = {3'b000, lvl_nib} << TRIG_UNIT_SHIFT; // RULE14
		end else begin
			case (ctl_sel)
				2'd0: lvl = is_tx ? SEL_TX_LVL0 : SEL_RX_LVL0;
				2'd1: lvl = is_tx ? SEL_TX_LVL1 : SEL_RX_LVL1;
				2'd2: lvl = is_tx ? SEL_TX_LVL2 : SEL_RX_LVL2;
				default: lvl = is_tx ? SEL_TX_LVL3 : SEL_RX_LVL3;
			endcase
		end
		return lvl;
	endfunction : trig_lvl

	// Two-flop synchroniser for every host pin.
	logic [BUS_W-1:0] bus_s1_r;
	logic [BUS_W-1:0] bus_s2_r;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_s1_r <= {BUS_W{1'b1}};
			bus_s2_r <= {BUS_W{1'b1}};
		end else begin
			bus_s1_r <= {chan_a_select_n, chan_b_select_n, host_rd_n,
				host_wr_n, host_addr, host_wdata};
			bus_s2_r <= bus_s1_r;
		end
	end

	logic cs_a_n_s;
	logic cs_b_n_s;
	logic rd_n_s;
	logic wr_n_s;
	logic [2:0] addr_s;
	logic [7:0] wdata_s;
	assign {cs_a_n_s, cs_b_n_s, rd_n_s, wr_n_s, addr_s, wdata_s} = bus_s2_r;

	// A write is taken once, on the synchronised falling edge of the strobe.
	logic wr_n_d_r;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			wr_n_d_r <= 1'b1;
		else
			wr_n_d_r <= wr_n_s;
	end
	logic wr_take;
	assign wr_take = wr_n_d_r && !wr_n_s;

	logic [7:0] alt_a_r;
	logic [7:0] alt_b_r;
	logic sel_a;
	logic sel_b;
	logic any_sel;
	logic dual_wr;
	logic [7:0] mdm_sel;
	logic [2:0] line_sel;
	assign sel_a = !cs_a_n_s;
	assign sel_b = !cs_b_n_s;
	assign any_sel = sel_a || sel_b;
	// Channel A settings win when both selects are low.
	assign mdm_sel = sel_a ? modem_control_register_a : modem_control_register_b;
	assign line_sel = sel_a ? line_control_register_a[7:5]
		: line_control_register_b[7:5];
	assign dual_wr = sel_a ? alt_a_r[ALT_DUAL_BIT] : alt_b_r[ALT_DUAL_BIT];

	logic rdy_access;
	logic alt_access_a;
	logic alt_access_b;
	assign rdy_access = any_sel && mdm_sel[MODEM_READY_EN_BIT]
		&& !mdm_sel[MODEM_LOOPBACK_BIT]; // RULE6
	assign alt_access_a = line_control_register_a[7:5] == LINE_ALT_KEY; // RULE8
	assign alt_access_b = line_control_register_b[7:5] == LINE_ALT_KEY; // RULE8

	// Concurrent mode fans a write out to both channels.
	logic hit_a;
	logic hit_b;
	assign hit_a = wr_take && any_sel && (sel_a || dual_wr); // RULE9
	assign hit_b = wr_take && any_sel && (sel_b || dual_wr); // RULE9

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_strobe_a <= 1'b0;
			wr_strobe_b <= 1'b0;
			wr_addr <= 3'h0;
			wr_data <= 8'h00;
		end else begin
			wr_strobe_a <= hit_a;
			wr_strobe_b <= hit_b;
			if (wr_take) begin
				wr_addr <= addr_s;
				wr_data <= wdata_s;
			end
		end
	end

	// The readiness register is read only, so writes at 111 store nothing.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			alt_a_r <= ALT_FUNC_RESET;
		else if (hit_a && addr_s == ADDR_ALT_FUNC && alt_access_a) // RULE8
			alt_a_r <= wdata_s;
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			alt_b_r <= ALT_FUNC_RESET;
		else if (hit_b && addr_s == ADDR_ALT_FUNC && alt_access_b) // RULE8
			alt_b_r <= wdata_s;
	end

	// Live readiness comparisons.
	logic [6:0] tx_lvl_a;
	logic [6:0] tx_lvl_b;
	logic [6:0] rx_lvl_a;
	logic [6:0] rx_lvl_b;
	assign tx_lvl_a = trig_lvl(trigger_level_register_a[3:0],
		fifo_control_register_a[5:4], 1'b1);
	assign tx_lvl_b = trig_lvl(trigger_level_register_b[3:0],
		fifo_control_register_b[5:4], 1'b1);
	assign rx_lvl_a = trig_lvl(trigger_level_register_a[7:4],
		fifo_control_register_a[7:6], 1'b0);
	assign rx_lvl_b = trig_lvl(trigger_level_register_b[7:4],
		fifo_control_register_b[7:6], 1'b0);

	logic [7:0] ready_word;
	always_comb begin
		ready_word = 8'h00; // RULE5
		ready_word[RDY_TX_A_BIT] = 7'(tx_space_a) >= tx_lvl_a; // RULE1
		ready_word[RDY_TX_B_BIT] = 7'(tx_space_b) >= tx_lvl_b; // RULE2
		ready_word[RDY_RX_A_BIT] = 7'(rx_fill_a) > rx_lvl_a
			|| rx_timeout_a; // RULE3
		ready_word[RDY_RX_B_BIT] = 7'(rx_fill_b) > rx_lvl_b
			|| rx_timeout_b; // RULE4
	end

	// Read mux, refreshed every cycle while a read is in progress.
	logic rd_active;
	logic [7:0] rd_mux;
	assign rd_active = any_sel && !rd_n_s;
	always_comb begin
		if (addr_s == ADDR_FIFO_READY && rdy_access)
			rd_mux = ready_word; // RULE7
		else if (addr_s == ADDR_ALT_FUNC && line_sel == LINE_ALT_KEY)
			rd_mux = sel_a ? alt_a_r : alt_b_r; // RULE8
		else
			rd_mux = sel_a ? normal_rdata_a : normal_rdata_b;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			host_rdata <= RDATA_RESET;
			host_rdata_oe <= 1'b0;
		end else begin
			host_rdata_oe <= rd_active;
			if (rd_active)
				host_rdata <= rd_mux;
		end
	end

	// Driver enable follows pending transmit data in half-duplex mode.
	// The turnaround delay after the last stop bit is not applied here.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_driver_enable_out_a <= 1'b0;
			bus_driver_enable_out_b <= 1'b0;
		end else begin
			bus_driver_enable_out_a <= alt_a_r[ALT_HDX_BIT]
				&& tx_pending_a; // RULE13 RULE15
			bus_driver_enable_out_b <= alt_b_r[ALT_HDX_BIT]
				&& tx_pending_b; // RULE13 RULE15
		end
	end

	assign alternate_function_control_a = alt_a_r;
	assign alternate_function_control_b = alt_b_r;
	assign infrared_mode_enable_a = alt_a_r[ALT_SIR_BIT]; // RULE11
	assign infrared_mode_enable_b = alt_b_r[ALT_SIR_BIT]; // RULE11

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence s_rdy_read;
		rd_active && addr_s == ADDR_FIFO_READY && rdy_access;
	endsequence

	a_rdy_tx_a: assert property (s_rdy_read |=> // RULE1
		host_rdata[0] == $past(tx_space_a >= tx_lvl_a))
		else $error("tx ready A wrong");
	a_rdy_tx_b: assert property (s_rdy_read |=> // RULE2
		host_rdata[1] == $past(tx_space_b >= tx_lvl_b))
		else $error("tx ready B wrong");
	a_rdy_rx_a: assert property (s_rdy_read |=> // RULE3
		host_rdata[4] == $past(rx_fill_a > rx_lvl_a || rx_timeout_a))
		else $error("rx ready A wrong");
	a_rdy_rx_b: assert property (s_rdy_read |=> // RULE4
		host_rdata[5] == $past(rx_fill_b > rx_lvl_b || rx_timeout_b))
		else $error("rx ready B wrong");
	a_rdy_zero_bits: assert property (s_rdy_read |=> // RULE5
		host_rdata[3:2] == 2'b00 && host_rdata[7:6] == 2'b00)
		else $error("unused ready bits set");
	a_rdy_gated: assert property (rd_active && sel_a // RULE6
		&& addr_s == ADDR_FIFO_READY
		&& modem_control_register_a[MODEM_LOOPBACK_BIT]
		&& line_sel != LINE_ALT_KEY |=> host_rdata == $past(normal_rdata_a))
		else $error("ready read in loopback");
	a_concurrent_write_enable_fanout: assert property (wr_take && any_sel && dual_wr // RULE9
		|=> wr_strobe_a && wr_strobe_b)
		else $error("concurrent write not fanned out");
	a_alt_locked: assert property (hit_a && addr_s == ADDR_ALT_FUNC // RULE8
		&& !alt_access_a |=> $stable(alt_a_r))
		else $error("alternate function written without key");
	a_drv_follow: assert property (alt_a_r[ALT_HDX_BIT] // RULE15
		&& tx_pending_a ##1 alt_a_r[ALT_HDX_BIT] |-> bus_driver_enable_out_a)
		else $error("driver enable A not high");
	a_drv_off: assert property (!alt_b_r[ALT_HDX_BIT] // RULE13
		|=> !bus_driver_enable_out_b)
		else $error("driver enable B high outside half-duplex");

endmodule : frd_regs

//--- verif/frd_host.sv
// Host processor model for the parallel register bus of frd_regs.
// Assumes one caller at a time, and that the bench drives at falling edges.
`timescale 1ns/100ps

module frd_host (
	// Clock.
	input wire logic ref_clk,
	// Bus pins.
	output logic chan_a_select_n,
	output logic chan_b_select_n,
	output logic host_rd_n,
	output logic host_wr_n,
	output logic [2:0] host_addr,
	output logic [7:0] host_wdata,
	input wire logic [7:0] host_rdata,
	input wire logic host_rdata_oe
);
	// Output enable seen when the latest read data was taken.
	logic last_oe;

	initial begin
		last_oe = 1'b0;
		{chan_b_select_n, chan_a_select_n} = 2'b11;
		host_rd_n = 1'b1;
		host_wr_n = 1'b1;
		host_addr = 3'h0;
		host_wdata = 8'h00;
	end

	// The pins are synchronised, so everything settles three clocks early.
	task automatic setup(input logic [1:0] sel_n, input logic [2:0] a,
		input logic [7:0] d);
		@(negedge ref_clk);
		{chan_b_select_n, chan_a_select_n} = sel_n;
		host_addr = a;
		host_wdata = d;
		repeat (3) @(negedge ref_clk);
	endtask : setup

	// Released lines show the inverse so a stale value cannot match by luck.
	task automatic idle();
		repeat (3) @(negedge ref_clk);
		{chan_b_select_n, chan_a_select_n} = 2'b11;
		host_wdata = ~host_wdata;
		host_addr = ~host_addr;
	endtask : idle

	task automatic wr(input logic [1:0] sel_n, input logic [2:0] a,
		input logic [7:0] d);
		setup(sel_n, a, d);
		host_wr_n = 1'b0;
		repeat (4) @(negedge ref_clk);
		host_wr_n = 1'b1;
		idle();
	endtask : wr

	task automatic rd(input logic [1:0] sel_n, input logic [2:0] a,
		output logic [7:0] d);
		setup(sel_n, a, ~host_wdata);
		host_rd_n = 1'b0;
		// Taken at a falling edge, long after the registered data settled.
		repeat (6) @(negedge ref_clk);
		d = host_rdata;
		last_oe = host_rdata_oe;
		host_rd_n = 1'b1;
		idle();
	endtask : rd
endmodule : frd_host

//--- verif/frd_regs_tb.sv
// Self-checking bench for frd_regs with a host model on the register bus.
// Assumes default parameters: 64-entry FIFOs and 7-bit counts.
`timescale 1ns/100ps

module frd_regs_tb;
	import frd_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic chan_a_select_n, chan_b_select_n, host_rd_n, host_wr_n;
	logic [2:0] host_addr, wr_addr;
	logic [7:0] host_wdata, host_rdata, wr_data;
	logic host_rdata_oe, wr_strobe_a, wr_strobe_b;
	logic [6:0] tx_space_a = 7'h00, tx_space_b = 7'h00;
	logic [6:0] rx_fill_a = 7'h00, rx_fill_b = 7'h00;
	logic rx_timeout_a = 1'b0, rx_timeout_b = 1'b0;
	logic tx_pending_a = 1'b0, tx_pending_b = 1'b0;
	logic [7:0] trigger_level_register_a = 8'h00;
	logic [7:0] trigger_level_register_b = 8'h00;
	logic [7:0] fifo_control_register_a = 8'h00;
	logic [7:0] fifo_control_register_b = 8'h00;
	logic [7:0] modem_control_register_a = 8'h00;
	logic [7:0] modem_control_register_b = 8'h00;
	logic [7:0] line_control_register_a = 8'h00;
	logic [7:0] line_control_register_b = 8'h00;
	logic [7:0] normal_rdata_a = 8'hA5, normal_rdata_b = 8'h5A;
	logic [7:0] alternate_function_control_a, alternate_function_control_b;
	logic infrared_mode_enable_a, infrared_mode_enable_b;
	logic bus_driver_enable_out_a, bus_driver_enable_out_b;
	int fail_count = 0;
	int n_checks = 0;
	int n_str_a = 0;
	int n_str_b = 0;

	always #2 ref_clk = ~ref_clk;

	always @(negedge ref_clk) begin
		if (wr_strobe_a === 1'b1) n_str_a++;
		if (wr_strobe_b === 1'b1) n_str_b++;
	end

	frd_regs frd_regs_i (.ref_clk, .rst_n, .chan_a_select_n,
		.chan_b_select_n, .host_rd_n, .host_wr_n, .host_addr, .host_wdata,
		.host_rdata, .host_rdata_oe, .tx_space_a, .rx_fill_a, .rx_timeout_a,
		.trigger_level_register_a, .fifo_control_register_a,
		.modem_control_register_a, .line_control_register_a, .tx_pending_a,
		.normal_rdata_a, .tx_space_b, .rx_fill_b, .rx_timeout_b,
		.trigger_level_register_b, .fifo_control_register_b,
		.modem_control_register_b, .line_control_register_b, .tx_pending_b,
		.normal_rdata_b, .wr_strobe_a, .wr_strobe_b, .wr_addr, .wr_data,
		.alternate_function_control_a, .alternate_function_control_b,
		.infrared_mode_enable_a, .infrared_mode_enable_b,
		.bus_driver_enable_out_a, .bus_driver_enable_out_b);

	frd_host frd_host_i (.ref_clk, .chan_a_select_n, .chan_b_select_n,
		.host_rd_n, .host_wr_n, .host_addr, .host_wdata, .host_rdata,
		.host_rdata_oe);

	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Trigger A from the level register (8 and 12), B from FIFO control.
	task automatic t_ready();
		logic [7:0] d;
		@(negedge ref_clk);
		trigger_level_register_a = 8'h32;
		fifo_control_register_b = 8'h60;
		modem_control_register_a = 8'h04;
		modem_control_register_b = 8'h04;
		tx_space_a = 7'h08;
		tx_space_b = SEL_TX_LVL2 - 7'h01;
		rx_fill_a = 7'h0C;
		rx_fill_b = SEL_RX_LVL1 + 7'h01;
		frd_host_i.rd(2'b10, ADDR_FIFO_READY, d);
		chk("ready word a", 8'h21, d);
		tx_space_a = 7'h07;
		tx_space_b = SEL_TX_LVL2;
		rx_fill_a = 7'h0D;
		rx_fill_b = SEL_RX_LVL1;
		rx_timeout_b = 1'b1;
		frd_host_i.wr(2'b01, ADDR_FIFO_READY, 8'hFF);
		frd_host_i.rd(2'b01, ADDR_FIFO_READY, d);
		chk("ready word b", 8'h32, d);
	endtask : t_ready

	task automatic t_gate();
		logic [7:0] d;
		@(negedge ref_clk);
		modem_control_register_a = 8'h00;
		frd_host_i.rd(2'b10, ADDR_FIFO_READY, d);
		chk("ready disabled", normal_rdata_a, d);
		chk("read oe", 8'h01, {7'h00, frd_host_i.last_oe});
		chk("oe released", 8'h00, {7'h00, host_rdata_oe});
		modem_control_register_a = 8'h14;
		frd_host_i.rd(2'b10, ADDR_FIFO_READY, d);
		chk("ready loopback", normal_rdata_a, d);
	endtask : t_gate

	// Only the mode bit is set; no serial rate is programmed here.
	task automatic t_afr();
		@(negedge ref_clk);
		line_control_register_a = 8'h03;
		frd_host_i.wr(2'b10, ADDR_ALT_FUNC, 8'h02);
		chk("alt locked", ALT_FUNC_RESET, alternate_function_control_a);
		line_control_register_a = {LINE_ALT_KEY, 5'h03};
		frd_host_i.wr(2'b10, ADDR_ALT_FUNC, 8'h02);
		chk("alt a", 8'h02, alternate_function_control_a);
		chk("sir a", 8'h01, {7'h00, infrared_mode_enable_a});
		chk("alt b", ALT_FUNC_RESET, alternate_function_control_b);
	endtask : t_afr

	// Both keys are opened before concurrent writing is turned on.
	task automatic t_concurrent_write_enable();
		int sa;
		int sb;
		@(negedge ref_clk);
		line_control_register_b = {LINE_ALT_KEY, 5'h00};
		frd_host_i.wr(2'b10, ADDR_ALT_FUNC, 8'h01);
		sa = n_str_a;
		sb = n_str_b;
		frd_host_i.wr(2'b10, ADDR_ALT_FUNC, 8'h03);
		chk("dual alt b", 8'h03, alternate_function_control_b);
		chk("dual strobes", 8'h11,
			{4'(n_str_a - sa), 4'(n_str_b - sb)});
		chk("dual data", 8'h03, wr_data);
		chk("dual addr", {5'h00, ADDR_ALT_FUNC}, {5'h00, wr_addr});
		chk("sir b", 8'h01, {7'h00, infrared_mode_enable_b});
		frd_host_i.wr(2'b10, ADDR_ALT_FUNC, 8'h00);
		chk("dual off b", 8'h00, alternate_function_control_b);
	endtask : t_concurrent_write_enable

	task automatic t_drv();
		@(negedge ref_clk);
		tx_pending_a = 1'b1;
		tx_pending_b = 1'b1;
		frd_host_i.wr(2'b10, ADDR_ALT_FUNC, 8'h04);
		chk("drv on", 8'h01,
			{6'h00, bus_driver_enable_out_b, bus_driver_enable_out_a});
		tx_pending_a = 1'b0;
		repeat (2) @(negedge ref_clk);
		chk("drv off", 8'h00,
			{6'h00, bus_driver_enable_out_b, bus_driver_enable_out_a});
	endtask : t_drv

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : finish_test

	initial begin
		repeat (8) @(posedge ref_clk);
		@(negedge ref_clk);
		rst_n = 1'b1;
		repeat (3) @(negedge ref_clk);
		chk("alt reset", ALT_FUNC_RESET, alternate_function_control_a);
		t_ready();
		t_gate();
		t_afr();
		t_concurrent_write_enable();
		t_drv();
		finish_test();
	end

	// Eleven bus cycles of eleven to thirteen clocks each fit well inside.
	initial begin
		#100000;
		fail_count++;
		finish_test();
	end
endmodule : frd_regs_tb
